// [logic/irq_ctrl_pkg.sv]
// Functional notes
// RL1 - Priority level is status msb over three low bits.
// RL2 - Software reads or clears msb; hardware sets; resets zero.
// RL3 - Unimplemented bits read zero, writes ignored.
// RL4 - Port one error request passes only when enabled.
// RL5 - Without port two, its enable reads zero.
// RL6 - Voltage and port two requests gated; enables reset zero.
package irq_ctrl_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // Register byte offsets.
   localparam logic [ADDR_W-1:0] CPU_CONTROL_OFFSET = 8'h00;
   localparam logic [ADDR_W-1:0] IRQ_ENABLE4_OFFSET = 8'h04;
   localparam logic [ADDR_W-1:0] EVENT_STATUS_OFFSET = 8'h08;
   localparam logic [ADDR_W-1:0] EVENT_MASK_OFFSET = 8'h0c;
   localparam logic [ADDR_W-1:0] PRIORITY_VIEW_OFFSET = 8'h10;

   // Field positions.
   localparam int PRIO_MSB_BIT = 3;
   localparam int VD_EN_BIT = 8;
   localparam int U2_EN_BIT = 2;
   localparam int U1_EN_BIT = 1;
   localparam int LOW_BITS_W = 3;
   localparam int LEVEL_W = 4;

   // Request gate lanes and event status bits.
   localparam int GATE_VD = 0;
   localparam int GATE_U1 = 1;
   localparam int GATE_U2 = 2;
   localparam int GATE_N = 3;
   localparam int EV_PRIO = 0;
   localparam int EV_VD = 1;
   localparam int EV_U1 = 2;
   localparam int EV_U2 = 3;
   localparam int EV_N = 4;

   // Values after reset.
   localparam logic PRIO_MSB_RESET = 1'b0;
   localparam logic ENABLE_RESET = 1'b0;
   localparam logic [EV_N-1:0] EVENT_RESET = 4'h0;

   // Bus responses.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

// [logic/irq_request_gate.sv]
`timescale 1ns/1ns
module irq_request_gate #(
   parameter int N = 3
) (
   // Clock and reset
   input  wire logic         aclk,
   input  wire logic         aresetn,
   // Requests and their enables
   input  wire logic [N-1:0] req,
   input  wire logic [N-1:0] en,
   // Forwarded requests
   output logic      [N-1:0] fwd
);
   import irq_ctrl_pkg::*;

   typedef struct packed {
      logic [N-1:0] fwd;
   } gate_s;

   gate_s        st;
   gate_s        next_st;
   logic [N-1:0] gated;

   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_lane
         assign gated[i] = req[i] & en[i];
      end
   endgenerate

   always_comb begin
      next_st = st;
      next_st.fwd = gated;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign fwd = st.fwd;

endmodule

// [logic/axil_regs_port.sv]
`timescale 1ns/1ns
module axil_regs_port (
   // Clock and reset
   input  wire logic                             aclk,
   input  wire logic                             aresetn,
   // Write address and data
   input  wire logic [irq_ctrl_pkg::ADDR_W-1:0]  awaddr,
   input  wire logic                             awvalid,
   output logic                                  awready,
   input  wire logic [irq_ctrl_pkg::DATA_W-1:0]  wdata,
   input  wire logic [3:0]                       wstrb,
   input  wire logic                             wvalid,
   output logic                                  wready,
   // Write response
   output logic [1:0]                            bresp,
   output logic                                  bvalid,
   input  wire logic                             bready,
   // Read address and data
   input  wire logic [irq_ctrl_pkg::ADDR_W-1:0]  araddr,
   input  wire logic                             arvalid,
   output logic                                  arready,
   output logic [irq_ctrl_pkg::DATA_W-1:0]       rdata,
   output logic [1:0]                            rresp,
   output logic                                  rvalid,
   input  wire logic                             rready,
   // Register file side
   output logic                                  wr_en,
   output logic [irq_ctrl_pkg::ADDR_W-1:0]       wr_addr,
   output logic [irq_ctrl_pkg::DATA_W-1:0]       wr_data,
   output logic [3:0]                            wr_strb,
   input  wire logic                             wr_hit,
   output logic [irq_ctrl_pkg::ADDR_W-1:0]       rd_addr,
   input  wire logic [irq_ctrl_pkg::DATA_W-1:0]  rd_data,
   input  wire logic                             rd_hit
);
   import irq_ctrl_pkg::*;

   typedef struct packed {
      logic              aw_full;
      logic [ADDR_W-1:0] aw_addr;
      logic              w_full;
      logic [DATA_W-1:0] w_data;
      logic [3:0]        w_strb;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0]        rresp;
   } port_s;

   port_s st;
   port_s next_st;
   logic  rd_en;

   // Address and data are held until both are in, in either order.
   assign wr_en = st.aw_full & st.w_full & ~st.bvalid;
   assign rd_en = arvalid & ~st.rvalid;

   always_comb begin
      next_st = st;
      if (awvalid && !st.aw_full) begin
         next_st.aw_full = 1'b1;
         next_st.aw_addr = awaddr;
      end
      if (wvalid && !st.w_full) begin
         next_st.w_full = 1'b1;
         next_st.w_data = wdata;
         next_st.w_strb = wstrb;
      end
      if (wr_en) begin
         next_st.aw_full = 1'b0;
         next_st.w_full = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = wr_hit ? RESP_OKAY : RESP_DECERR;
      end
      if (st.bvalid && bready) begin
         next_st.bvalid = 1'b0;
      end
      if (rd_en) begin
         next_st.rvalid = 1'b1;
         next_st.rdata = rd_data;
         next_st.rresp = rd_hit ? RESP_OKAY : RESP_DECERR;
      end else if (st.rvalid && rready) begin
         next_st.rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign awready = ~st.aw_full;
   assign wready = ~st.w_full;
   assign bvalid = st.bvalid;
   assign bresp = st.bresp;
   assign arready = ~st.rvalid;
   assign rvalid = st.rvalid;
   assign rdata = st.rdata;
   assign rresp = st.rresp;
   assign wr_addr = st.aw_addr;
   assign wr_data = st.w_data;
   assign wr_strb = st.w_strb;
   assign rd_addr = araddr;

endmodule

// [logic/cpu_priority_irq_enables.sv]
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
module cpu_priority_irq_enables #(
   parameter bit HAS_SERIAL_PORT2 = 1'b1
) (
   // Clock and reset
   input  wire logic                                 aclk,
   input  wire logic                                 aresetn,
   // AXI4-Lite write address and data
   input  wire logic [irq_ctrl_pkg::ADDR_W-1:0]      awaddr,
   input  wire logic                                 awvalid,
   output logic                                      awready,
   input  wire logic [irq_ctrl_pkg::DATA_W-1:0]      wdata,
   input  wire logic [3:0]                           wstrb,
   input  wire logic                                 wvalid,
   output logic                                      wready,
   // AXI4-Lite write response
   output logic [1:0]                                bresp,
   output logic                                      bvalid,
   input  wire logic                                 bready,
   // AXI4-Lite read
   input  wire logic [irq_ctrl_pkg::ADDR_W-1:0]      araddr,
   input  wire logic                                 arvalid,
   output logic                                      arready,
   output logic [irq_ctrl_pkg::DATA_W-1:0]           rdata,
   output logic [1:0]                                rresp,
   output logic                                      rvalid,
   input  wire logic                                 rready,
   // CPU core side
   input  wire logic [irq_ctrl_pkg::LOW_BITS_W-1:0]  priority_level_low_bits,
   input  wire logic                                 priority_msb_set,
   output logic [irq_ctrl_pkg::LEVEL_W-1:0]          priority_level,
   // Peripheral requests
   input  wire logic                                 voltage_detect_req,
   input  wire logic                                 serial_port1_error_req,
   input  wire logic                                 serial_port2_error_req,
   // Requests forwarded to the CPU
   output logic                                      voltage_detect_irq,
   output logic                                      serial_port1_error_irq,
   output logic                                      serial_port2_error_irq,
   // Summary interrupt
   output logic                                      event_irq
);
   import irq_ctrl_pkg::*;

   typedef struct packed {
      logic               msb;
      logic               en_vd;
      logic               en_u2;
      logic               en_u1;
      logic [EV_N-1:0]    status;
      logic [EV_N-1:0]    mask;
      logic [LEVEL_W-1:0] level;
   } ctrl_s;

   ctrl_s              st;
   ctrl_s              next_st;
   logic               wr_en;
   logic [ADDR_W-1:0]  wr_addr;
   logic [DATA_W-1:0]  wr_data;
   logic [3:0]         wr_strb;
   logic               wr_hit;
   logic [ADDR_W-1:0]  rd_addr;
   logic [DATA_W-1:0]  rd_data;
   logic               rd_hit;
   logic [ADDR_W-1:0]  wa;
   logic [ADDR_W-1:0]  ra;
   logic               clr_msb;
   logic [EV_N-1:0]    clr_ev;
   logic [EV_N-1:0]    events;
   logic [GATE_N-1:0]  gate_req;
   logic [GATE_N-1:0]  gate_en;
   logic [GATE_N-1:0]  gate_fwd;

   axil_regs_port u_port (
      .aclk    (aclk),
      .aresetn (aresetn),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),
      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready),
      .wr_en   (wr_en),
      .wr_addr (wr_addr),
      .wr_data (wr_data),
      .wr_strb (wr_strb),
      .wr_hit  (wr_hit),
      .rd_addr (rd_addr),
      .rd_data (rd_data),
      .rd_hit  (rd_hit)
   );

   // Each request reaches the CPU one cycle after it meets its enable.
   assign gate_req[GATE_VD] = voltage_detect_req;
   assign gate_req[GATE_U1] = serial_port1_error_req;
   assign gate_req[GATE_U2] = serial_port2_error_req;
   assign gate_en[GATE_VD] = st.en_vd; // RL6
   assign gate_en[GATE_U1] = st.en_u1; // RL4
   assign gate_en[GATE_U2] = st.en_u2; // RL6

   irq_request_gate #(
      .N (GATE_N)
   ) u_gate (
      .aclk    (aclk),
      .aresetn (aresetn),
      .req     (gate_req),
      .en      (gate_en),
      .fwd     (gate_fwd)
   );

   // Word decode: the two low address bits are ignored.
   assign wa = {wr_addr[ADDR_W-1:2], 2'h0};
   assign ra = {rd_addr[ADDR_W-1:2], 2'h0};

   assign wr_hit = (wa == CPU_CONTROL_OFFSET) ||
                   (wa == IRQ_ENABLE4_OFFSET) ||
                   (wa == EVENT_STATUS_OFFSET) ||
                   (wa == EVENT_MASK_OFFSET) ||
                   (wa == PRIORITY_VIEW_OFFSET);

   // Only a zero written to the status bit clears it.
   assign clr_msb = wr_en && (wa == CPU_CONTROL_OFFSET) && wr_strb[0] &&
                    !wr_data[PRIO_MSB_BIT];

   assign clr_ev = (wr_en && (wa == EVENT_STATUS_OFFSET) && wr_strb[0]) ?
                   wr_data[EV_N-1:0] : EVENT_RESET;

   always_comb begin
      events = EVENT_RESET;
      events[EV_PRIO] = priority_msb_set;
      events[EV_VD] = gate_fwd[GATE_VD];
      events[EV_U1] = gate_fwd[GATE_U1];
      events[EV_U2] = gate_fwd[GATE_U2];
   end

   always_comb begin
      next_st = st;
      // Hardware set outranks a clear in the same cycle.
      next_st.msb = (st.msb & ~clr_msb) | priority_msb_set; // RL2
      if (wr_en && (wa == IRQ_ENABLE4_OFFSET)) begin
         if (wr_strb[1]) begin
            next_st.en_vd = wr_data[VD_EN_BIT]; // RL6
         end
         if (wr_strb[0]) begin
            next_st.en_u1 = wr_data[U1_EN_BIT]; // RL4
            next_st.en_u2 = HAS_SERIAL_PORT2 & wr_data[U2_EN_BIT]; // RL5
         end
      end
      next_st.status = (st.status & ~clr_ev) | events;
      if (wr_en && (wa == EVENT_MASK_OFFSET) && wr_strb[0]) begin
         next_st.mask = wr_data[EV_N-1:0];
      end
      next_st.level = {next_st.msb, priority_level_low_bits}; // RL1
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st.msb <= PRIO_MSB_RESET; // RL2
         st.en_vd <= ENABLE_RESET; // RL6
         st.en_u2 <= ENABLE_RESET;
         st.en_u1 <= ENABLE_RESET;
         st.status <= EVENT_RESET;
         st.mask <= EVENT_RESET;
         st.level <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Reads have no side effect, so decoding straight from the bus address
   // is safe; the port registers the word when it takes the request.
   // Read mux; every bit not listed stays zero.
   always_comb begin
      rd_data = '0;
      rd_hit = 1'b1;
      case (ra)
         CPU_CONTROL_OFFSET: begin
            rd_data[PRIO_MSB_BIT] = st.msb; // RL3
         end
         IRQ_ENABLE4_OFFSET: begin
            rd_data[VD_EN_BIT] = st.en_vd; // RL3
            rd_data[U2_EN_BIT] = st.en_u2 & HAS_SERIAL_PORT2; // RL5
            rd_data[U1_EN_BIT] = st.en_u1;
         end
         EVENT_STATUS_OFFSET: begin
            rd_data[EV_N-1:0] = st.status;
         end
         EVENT_MASK_OFFSET: begin
            rd_data[EV_N-1:0] = st.mask;
         end
         PRIORITY_VIEW_OFFSET: begin
            rd_data[LEVEL_W-1:0] = st.level;
         end
         default: begin
            rd_hit = 1'b0;
         end
      endcase
   end

   assign priority_level = st.level;
   assign voltage_detect_irq = gate_fwd[GATE_VD];
   assign serial_port1_error_irq = gate_fwd[GATE_U1];
   assign serial_port2_error_irq = gate_fwd[GATE_U2];
   assign event_irq = |(st.status & st.mask);

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   chk_level_low_bits: assert property ( // RL1
      priority_level[2:0] == $past(priority_level_low_bits))
      else $error("priority low bits not taken from core");

   chk_level_msb_top: assert property ( // RL1
      priority_level == {st.msb, $past(priority_level_low_bits)})
      else $error("priority level not msb over low bits");

   chk_msb_no_sw_set: assert property ( // RL2
      !st.msb && !priority_msb_set |=> !st.msb)
      else $error("priority msb set without hardware event");

   chk_msb_hw_set: assert property ( // RL2
      priority_msb_set |=> st.msb && priority_level[3])
      else $error("priority msb not set by hardware");

   chk_msb_sw_clear: assert property ( // RL2
      clr_msb && !priority_msb_set |=> !st.msb && !priority_level[3])
      else $error("priority msb not cleared by zero write");

   chk_reset_values: assert property ( // RL2
      @(posedge aclk) disable iff (1'b0)
      !aresetn |=> !st.msb && !st.en_vd && !st.en_u1 && !st.en_u2)
      else $error("control bits not zero after reset");

   chk_unimpl_control: assert property ( // RL3
      ra == CPU_CONTROL_OFFSET |-> (rd_data & 32'hfffffff7) == '0)
      else $error("unimplemented control bit reads nonzero");

   chk_unimpl_enable: assert property ( // RL3
      ra == IRQ_ENABLE4_OFFSET |-> (rd_data & 32'hfffffef9) == '0)
      else $error("unimplemented enable bit reads nonzero");

   chk_port1_blocked: assert property ( // RL4
      !st.en_u1 |=> !serial_port1_error_irq)
      else $error("port one error passed while disabled");

   chk_port1_passed: assert property ( // RL4
      st.en_u1 && serial_port1_error_req |=> serial_port1_error_irq)
      else $error("port one error not forwarded");

   chk_port2_absent: assert property ( // RL5
      !HAS_SERIAL_PORT2 |-> !st.en_u2 && !serial_port2_error_irq)
      else $error("absent port two enable became set");

   chk_vd_gate: assert property ( // RL6
      voltage_detect_irq == $past(voltage_detect_req && st.en_vd))
      else $error("voltage detect request gating wrong");

   chk_port2_gate: assert property ( // RL6
      serial_port2_error_irq ==
      $past(serial_port2_error_req && st.en_u2))
      else $error("port two error gating wrong");

   chk_status_sticky: assert property (
      st.status[EV_PRIO] && !clr_ev[EV_PRIO] |=> st.status[EV_PRIO])
      else $error("event status bit lost without clear");

   chk_event_set_wins: assert property (
      |events |=> (st.status & $past(events)) == $past(events))
      else $error("event lost to a clear in the same cycle");

   chk_status_clear: assert property (
      (clr_ev & ~events) != '0 |=> (st.status & $past(clr_ev & ~events)) == '0)
      else $error("event status bit not cleared by one");

   chk_enable_stable: assert property ( // RL6
      !(wr_en && wa == IRQ_ENABLE4_OFFSET) |=>
      $stable({st.en_vd, st.en_u2, st.en_u1}))
      else $error("enable bit changed without a write");

   chk_port1_idle: assert property ( // RL4
      !serial_port1_error_req |=> !serial_port1_error_irq)
      else $error("port one error forwarded without request");

   chk_bresp_once: assert property (
      bvalid && bready |=> !bvalid)
      else $error("write response repeated after handshake");

   chk_rdata_once: assert property (
      rvalid && rready |=> !rvalid)
      else $error("read data repeated after handshake");

   cov_msb_set: cover property (priority_msb_set ##1 st.msb);
   cov_msb_clear: cover property (st.msb ##1 clr_msb ##1 !st.msb);
   cov_port1_fwd: cover property (serial_port1_error_irq);
   cov_event_irq: cover property (!event_irq ##1 event_irq);

endmodule

// [verif/cpu_periph_model.sv]
`timescale 1ns/1ns
module cpu_periph_model (
   // Clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // Commands from the bench
   input  wire logic [2:0] cmd_req,
   input  wire logic [2:0] cmd_low,
   input  wire logic       cmd_set,
   // Core and peripheral lines toward the block
   output logic            voltage_detect_req,
   output logic            serial_port1_error_req,
   output logic            serial_port2_error_req,
   output logic [2:0]      priority_level_low_bits,
   output logic            priority_msb_set
);
   // Everything is launched from a register on the rising edge, as the
   // real core and peripherals would, so the block never sees a glitch.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         voltage_detect_req      <= 1'b0;
         serial_port1_error_req  <= 1'b0;
         serial_port2_error_req  <= 1'b0;
         priority_level_low_bits <= 3'h0;
         priority_msb_set        <= 1'b0;
      end else begin
         voltage_detect_req      <= cmd_req[0];
         serial_port1_error_req  <= cmd_req[1];
         serial_port2_error_req  <= cmd_req[2];
         priority_level_low_bits <= cmd_low;
         priority_msb_set        <= cmd_set;
      end
   end
endmodule

// [verif/tb.sv]
`timescale 1ns/1ns
module tb;
   import irq_ctrl_pkg::*;
   logic              aclk    = 1'b0;
   logic              aresetn = 1'b0;
   logic [ADDR_W-1:0] awaddr  = 8'h00;
   logic [ADDR_W-1:0] araddr  = 8'h00;
   logic [DATA_W-1:0] wdata   = 32'h0;
   logic [3:0]        wstrb   = 4'h0;
   logic              awvalid = 1'b0;
   logic              wvalid  = 1'b0;
   logic              bready  = 1'b0;
   logic              arvalid = 1'b0;
   logic              rready  = 1'b0;
   logic [2:0]        cmd_req = 3'h0;
   logic [2:0]        cmd_low = 3'h0;
   logic              cmd_set = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, event_irq;
   logic [1:0]        bresp, rresp;
   logic [DATA_W-1:0] rdata;
   logic [2:0]        low_bits;
   logic [3:0]        priority_level;
   logic vd_req, u1_req, u2_req, msb_set, vd_irq, u1_irq, u2_irq;
   logic [2:0]        irq_vec;
   logic [DATA_W-1:0] rdata_np;
   logic [DATA_W-1:0] np_seen;
   logic              u2_irq_np;
   int                bad_count   = 0;
   int                check_count = 0;

   assign irq_vec = {u2_irq, u1_irq, vd_irq};
   always #4 aclk = ~aclk;

   cpu_priority_irq_enables i_dut (
      .aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .priority_level_low_bits(low_bits), .priority_msb_set(msb_set),
      .priority_level(priority_level),
      .voltage_detect_req(vd_req), .serial_port1_error_req(u1_req),
      .serial_port2_error_req(u2_req), .voltage_detect_irq(vd_irq),
      .serial_port1_error_irq(u1_irq), .serial_port2_error_irq(u2_irq),
      .event_irq(event_irq)
   );

   // A second copy without port two shares the bus and the requests; its
   // timing is identical, so its read data can be taken at the same point.
   cpu_priority_irq_enables #(
      .HAS_SERIAL_PORT2 (1'b0)
   ) i_dut_np (
      .aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(),
      .bresp(), .bvalid(), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(),
      .rdata(rdata_np), .rresp(), .rvalid(), .rready(rready),
      .priority_level_low_bits(low_bits), .priority_msb_set(msb_set),
      .priority_level(),
      .voltage_detect_req(vd_req), .serial_port1_error_req(u1_req),
      .serial_port2_error_req(u2_req), .voltage_detect_irq(),
      .serial_port1_error_irq(), .serial_port2_error_irq(u2_irq_np),
      .event_irq()
   );

   cpu_periph_model i_model (
      .aclk(aclk), .aresetn(aresetn), .cmd_req(cmd_req),
      .cmd_low(cmd_low), .cmd_set(cmd_set),
      .voltage_detect_req(vd_req), .serial_port1_error_req(u1_req),
      .serial_port2_error_req(u2_req), .priority_level_low_bits(low_bits),
      .priority_msb_set(msb_set)
   );

   task automatic print_verdict();
      $display("checks=%0d errors=%0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Ready is judged at the falling edge, where it has settled for the
   // rising edge that follows and that edge makes the transfer.
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                            output logic [1:0] r);
      logic ta, tw, tk;
      @(posedge aclk);
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= d;
      wstrb   <= 4'hf;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (int n = 0; n < 64; n++) begin
         @(negedge aclk);
         ta = awvalid & awready;
         tw = wvalid & wready;
         tk = bvalid;
         r  = bresp;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tk) begin
            bready <= 1'b0;
            return;
         end
      end
      bad_count++;
      print_verdict();
   endtask

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                           output logic [1:0] r);
      logic ta, tk;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (int n = 0; n < 64; n++) begin
         @(negedge aclk);
         ta = arvalid & arready;
         tk = rvalid;
         d  = rdata;
         np_seen = rdata_np;
         r  = rresp;
         @(posedge aclk);
         if (ta) arvalid <= 1'b0;
         if (tk) begin
            rready <= 1'b0;
            return;
         end
      end
      bad_count++;
      print_verdict();
   endtask

   task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      axi_write(a, d, r);
      check({30'h0, r}, {30'h0, RESP_OKAY});
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0]  r;
      axi_read(a, d, r);
      check(d, exp);
      check({30'h0, r}, {30'h0, RESP_OKAY});
   endtask

   // The model and the request gate each add one register stage.
   task automatic settle();
      repeat (3) @(posedge aclk);
      @(negedge aclk);
   endtask

   task automatic test_reset_values();
      rd_chk(CPU_CONTROL_OFFSET, 32'h0);
      rd_chk(IRQ_ENABLE4_OFFSET, 32'h0);
      rd_chk(EVENT_STATUS_OFFSET, 32'h0);
      rd_chk(EVENT_MASK_OFFSET, 32'h0);
      rd_chk(PRIORITY_VIEW_OFFSET, 32'h0);
      @(negedge aclk);
      check({31'h0, event_irq}, 32'h0);
   endtask

   task automatic test_reg_access();
      wr_ok(IRQ_ENABLE4_OFFSET, 32'hffff_ffff);
      rd_chk(IRQ_ENABLE4_OFFSET, 32'h0000_0106);
      check(np_seen, 32'h0000_0102);
      wr_ok(CPU_CONTROL_OFFSET, 32'hffff_ffff);
      rd_chk(CPU_CONTROL_OFFSET, 32'h0);
      wr_ok(IRQ_ENABLE4_OFFSET, 32'h0);
      rd_chk(IRQ_ENABLE4_OFFSET, 32'h0);
   endtask

   task automatic test_gating();
      int en_pos[3] = '{VD_EN_BIT, U1_EN_BIT, U2_EN_BIT};
      for (int i = 0; i < 3; i++) begin
         @(posedge aclk);
         cmd_req <= 3'(1 << i);
         settle();
         check({29'h0, irq_vec}, 32'h0);
         wr_ok(IRQ_ENABLE4_OFFSET, 32'(1 << en_pos[i]));
         settle();
         check({29'h0, irq_vec}, 32'(1 << i));
         check({31'h0, u2_irq_np}, 32'h0);
         wr_ok(IRQ_ENABLE4_OFFSET, 32'h0);
         settle();
         check({29'h0, irq_vec}, 32'h0);
         cmd_req <= 3'h0;
      end
      rd_chk(EVENT_STATUS_OFFSET, 32'h0000_000e);
      @(negedge aclk);
      check({31'h0, event_irq}, 32'h0);
   endtask

   task automatic test_priority();
      @(posedge aclk);
      cmd_low <= 3'h5;
      settle();
      check({28'h0, priority_level}, 32'h5);
      @(posedge aclk);
      cmd_set <= 1'b1;
      @(posedge aclk);
      cmd_set <= 1'b0;
      settle();
      check({28'h0, priority_level}, 32'hd);
      rd_chk(PRIORITY_VIEW_OFFSET, 32'hd);
      rd_chk(CPU_CONTROL_OFFSET, 32'h8);
      wr_ok(CPU_CONTROL_OFFSET, 32'hffff_fff7);
      settle();
      check({28'h0, priority_level}, 32'h5);
      rd_chk(CPU_CONTROL_OFFSET, 32'h0);
   endtask

   task automatic test_events();
      logic [31:0] d;
      logic [1:0]  r;
      wr_ok(EVENT_MASK_OFFSET, 32'h1);
      @(negedge aclk);
      check({31'h0, event_irq}, 32'h1);
      wr_ok(EVENT_STATUS_OFFSET, 32'h1);
      @(negedge aclk);
      check({31'h0, event_irq}, 32'h0);
      rd_chk(EVENT_STATUS_OFFSET, 32'h0000_000e);
      wr_ok(EVENT_MASK_OFFSET, 32'hf);
      rd_chk(EVENT_MASK_OFFSET, 32'hf);
      @(negedge aclk);
      check({31'h0, event_irq}, 32'h1);
      wr_ok(EVENT_STATUS_OFFSET, 32'hf);
      @(negedge aclk);
      check({31'h0, event_irq}, 32'h0);
      // An unmapped place must answer with an error and change nothing.
      // This place would alias onto the enables if upper bits were dropped.
      axi_write(8'h24, 32'hffff_ffff, r);
      check({30'h0, r}, {30'h0, RESP_DECERR});
      axi_read(8'h24, d, r);
      check(d, 32'h0);
      check({30'h0, r}, {30'h0, RESP_DECERR});
      rd_chk(IRQ_ENABLE4_OFFSET, 32'h0);
   endtask

   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      test_reset_values();
      test_reg_access();
      test_gating();
      test_priority();
      test_events();
      print_verdict();
   end
endmodule
